/* logic/ptpi_regs.svh */
`ifndef PTPI_REGS_SVH
`define PTPI_REGS_SVH

// Register byte offsets
`define PTPI_ADDR_W          8
`define PTPI_ADDR_CFG        8'h00
`define PTPI_ADDR_MODE       8'h04
`define PTPI_ADDR_GEAR       8'h08
`define PTPI_ADDR_POSITION_DONE_OUT       8'h0C
`define PTPI_ADDR_DEV        8'h10
`define PTPI_ADDR_STAT       8'h14
`define PTPI_ADDR_RES        8'h18

// Configuration fields
`define PTPI_CFG_CLRPOL      1:0
`define PTPI_CFG_FMT         5:4
`define PTPI_CFG_INV_DIR     8
`define PTPI_CFG_INV_STEP    9
`define PTPI_CFG_MULT        13:12
`define PTPI_CFG_MASK        32'h0000_3333
`define PTPI_MODE_CTRL       5:4
`define PTPI_MODE_BUSENC     8
`define PTPI_MODE_MASK       32'h0000_0130
`define PTPI_GEAR_MASK       32'h0000_FFFF
`define PTPI_STAT_DONE       0
`define PTPI_STAT_LOOP       1
`define PTPI_STAT_CLEAR      2

// Field codes
`define PTPI_CTRL_SPEED      2'h0
`define PTPI_CTRL_POS        2'h1
`define PTPI_CTRL_TRQ        2'h2
`define PTPI_FMT_STEP_DIR    2'h0
`define PTPI_FMT_CW_CCW      2'h1
`define PTPI_FMT_QUAD        2'h3
`define PTPI_MULT_X1         2'h0
`define PTPI_MULT_X2         2'h1
`define PTPI_CLR_SVOFF       2'h0
`define PTPI_CLR_NEVER       2'h1
`define PTPI_CLR_BOTH        2'h2

// Reset values and constants
`define PTPI_GEAR_RST        32'h0000_0001
`define PTPI_POSITION_DONE_OUT_RST        32'h0000_000A
`define PTPI_INC_LINES       32'h0000_09C4
`define PTPI_QUAD_FACTOR     32'h0000_0004
`define PTPI_BUS_ENC_RES     32'h0020_0000
`define PTPI_RESP_OKAY       2'h0
`define PTPI_RESP_SLVERR     2'h2

`endif

/* logic/ptpi_pkg.sv */
package ptpi_pkg;
   typedef logic        [31:0] ptpi_word_t;
   typedef logic signed [31:0] ptpi_dev_t;
   typedef enum logic [1:0] {
      PTPI_SPEED,
      PTPI_POSITION,
      PTPI_TORQUE
   } ptpi_ctrl_t;
endpackage

/* logic/ptpi_sync.sv */
`timescale 1ns/100ps
module ptpi_sync
   import ptpi_pkg::*;
#(
   parameter int W = 5
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               meta_q[i] <= 1'b0;
               q[i]      <= 1'b0;
            end else begin
               meta_q[i] <= d[i];
               q[i]      <= meta_q[i];
            end
         end
      end
   endgenerate

   a_sync_two_stage: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn, 2) && $past(aresetn) |-> q == $past(d, 2))
      else $error("synchroniser output does not follow input after two edges");
endmodule

/* logic/ptpi_decode.sv */
`timescale 1ns/100ps
`include "ptpi_regs.svh"
module ptpi_decode
   import ptpi_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       en,
   input  wire logic [1:0] fmt,
   input  wire logic [1:0] mult,
   input  wire logic       step,
   input  wire logic       dir,
   output logic            cmd_valid,
   output logic            cmd_rev
);
   logic step_q;
   logic dir_q;
   logic v_d;
   logic rev_d;
   logic rise_s;
   logic rise_d;
   logic edge_a;
   logic edge_b;

   assign rise_s = step & ~step_q;
   assign rise_d = dir & ~dir_q;
   assign edge_a = step ^ step_q;
   assign edge_b = dir ^ dir_q;

   always_comb begin
      v_d   = 1'b0;
      rev_d = 1'b0;
      case (fmt)
         `PTPI_FMT_STEP_DIR: begin
            v_d   = rise_s;
            rev_d = ~dir;
         end
         `PTPI_FMT_CW_CCW: begin
            // Coincident pulses cancel
            v_d   = rise_s ^ rise_d;
            rev_d = rise_d;
         end
         `PTPI_FMT_QUAD: begin
            // A leads B is forward; double edges are dropped as glitches
            rev_d = step_q ^ dir;
            case (mult)
               `PTPI_MULT_X1: v_d = rise_s & ~edge_b;
               `PTPI_MULT_X2: v_d = edge_a & ~edge_b;
               default:       v_d = edge_a ^ edge_b;
            endcase
         end
         default: begin
            v_d   = 1'b0;
            rev_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_q <= 1'b0;
         dir_q  <= 1'b0;
      end else begin
         step_q <= step;
         dir_q  <= dir;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_valid <= 1'b0;
         cmd_rev   <= 1'b0;
      end else begin
         cmd_valid <= en & v_d;
         cmd_rev   <= rev_d;
      end
   end

   sequence s_step_rise;
      en && fmt == `PTPI_FMT_STEP_DIR && step && !step_q;
   endsequence

   a_step_counts: assert property (@(posedge aclk) disable iff (!aresetn)
      s_step_rise |=> cmd_valid && cmd_rev == !$past(dir))
      else $error("step edge not turned into a command");

   a_quad_x4_count: assert property (@(posedge aclk) disable iff (!aresetn)
      en && fmt == `PTPI_FMT_QUAD && mult == 2'h2 && (edge_a != edge_b)
      |=> cmd_valid)
      else $error("quadrature x4 edge missed");

   a_disabled_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      !en |=> !cmd_valid)
      else $error("command produced while decoding disabled");
endmodule

/* logic/ptpi_top.sv */
// Notes on behaviour
// - Position mode: speed agree shows positioning done
// - Torque mode: speed agree forced high
// - Mode digit 1 enables pulse decoding
// - Formats: step-dir, forward-reverse, quadrature x1/x2/x4
// - Inversion code selects step/dir polarity
// - Clear zeroes the deviation counter
// - Position loop off while clear held
// - Policy 0: clear on servo-off only
// - Policy 1: never auto clear
// - Policy 2: clear on servo-off or overtravel
// - Feedback resolution four times encoder lines; fixed 0x0020_0000 with bus encoder
// - Each pulse is one gear-scaled command unit
`timescale 1ns/100ps
`include "ptpi_regs.svh"
module ptpi_top
   import ptpi_pkg::*;
(
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [`PTPI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   output logic      [1:0]              s_axi_bresp,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   input  wire logic [`PTPI_ADDR_W-1:0] s_axi_araddr,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   output logic      [31:0]             s_axi_rdata,
   output logic      [1:0]              s_axi_rresp,
   input  wire logic                    command_step_in,
   input  wire logic                    command_dir_in,
   input  wire logic                    deviation_clear_in,
   input  wire logic                    servo_on_in,
   input  wire logic                    overtravel_in,
   input  wire logic                    fb_count_valid,
   input  wire logic                    fb_count_rev,
   input  wire logic                    speed_match_in,
   output logic                         speed_agree_out,
   output logic                         position_done_out,
   output logic                         position_loop_en
);
   ptpi_word_t cfg_q;
   ptpi_word_t mode_q;
   ptpi_word_t gear_q;
   ptpi_word_t position_done_out_q;
   ptpi_dev_t  dev_q;
   ptpi_dev_t  dev_d;
   ptpi_word_t rd_word;
   ptpi_word_t res_word;
   ptpi_ctrl_t ctrl;

   logic                    aw_have_q;
   logic [`PTPI_ADDR_W-1:0] aw_addr_q;
   logic                    w_have_q;
   ptpi_word_t              w_data_q;
   logic [3:0]              w_strb_q;
   logic                    do_write;
   logic                    rd_hit;
   logic                    wr_hit;

   logic [4:0]  pin_s;
   logic        step_s;
   logic        dir_s;
   logic        clr_pin_act;
   logic        servo_off;
   logic        overtravel;
   logic        step_e;
   logic        dir_e;
   logic        pos_mode;
   logic        clear_act;
   logic        cmd_valid;
   logic        cmd_rev;
   logic        in_pos;
   logic [31:0] dev_mag;
   logic signed [33:0] sum;
   logic signed [33:0] cmd_term;
   logic signed [33:0] fb_term;

   function automatic ptpi_word_t merge_bytes(ptpi_word_t old, ptpi_word_t nw,
                                              logic [3:0] strb, ptpi_word_t mask);
      ptpi_word_t r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r & mask;
   endfunction

   // Bus slave: address and data taken in either order
   assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign do_write      = aw_have_q & w_have_q & ~s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
         w_have_q <= 1'b0;
      end
   end

   always_comb begin
      case (aw_addr_q)
         `PTPI_ADDR_CFG, `PTPI_ADDR_MODE, `PTPI_ADDR_GEAR, `PTPI_ADDR_POSITION_DONE_OUT: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `PTPI_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? `PTPI_RESP_OKAY : `PTPI_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q  <= '0;
         mode_q <= '0;
         gear_q <= `PTPI_GEAR_RST;
         position_done_out_q <= `PTPI_POSITION_DONE_OUT_RST;
      end else if (do_write) begin
         case (aw_addr_q)
            `PTPI_ADDR_CFG:  cfg_q  <= merge_bytes(cfg_q, w_data_q, w_strb_q, `PTPI_CFG_MASK);
            `PTPI_ADDR_MODE: mode_q <= merge_bytes(mode_q, w_data_q, w_strb_q, `PTPI_MODE_MASK);
            `PTPI_ADDR_GEAR: gear_q <= merge_bytes(gear_q, w_data_q, w_strb_q, `PTPI_GEAR_MASK);
            `PTPI_ADDR_POSITION_DONE_OUT: position_done_out_q <= merge_bytes(position_done_out_q, w_data_q, w_strb_q, '1);
            default: ;
         endcase
      end
   end

   assign res_word = mode_q[`PTPI_MODE_BUSENC] ? `PTPI_BUS_ENC_RES
                                                : 32'(`PTPI_INC_LINES * `PTPI_QUAD_FACTOR);

   always_comb begin
      rd_hit  = 1'b1;
      rd_word = '0;
      case (s_axi_araddr)
         `PTPI_ADDR_CFG:  rd_word = cfg_q;
         `PTPI_ADDR_MODE: rd_word = mode_q;
         `PTPI_ADDR_GEAR: rd_word = gear_q;
         `PTPI_ADDR_POSITION_DONE_OUT: rd_word = position_done_out_q;
         `PTPI_ADDR_DEV:  rd_word = dev_q;
         `PTPI_ADDR_STAT: begin
            rd_word[`PTPI_STAT_DONE]  = ~position_done_out;
            rd_word[`PTPI_STAT_LOOP]  = position_loop_en;
            rd_word[`PTPI_STAT_CLEAR] = clear_act;
         end
         `PTPI_ADDR_RES:  rd_word = res_word;
         default:         rd_hit  = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= `PTPI_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_hit ? `PTPI_RESP_OKAY : `PTPI_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ptpi_sync #(.W(5)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({overtravel_in, servo_on_in, deviation_clear_in,
                 command_dir_in, command_step_in}),
      .q       (pin_s)
   );

   assign step_s      = pin_s[0];
   assign dir_s       = pin_s[1];
   assign clr_pin_act = ~pin_s[2];
   assign servo_off   = ~pin_s[3];
   assign overtravel  = pin_s[4];

   assign step_e = step_s ^ cfg_q[`PTPI_CFG_INV_STEP];
   assign dir_e  = dir_s ^ cfg_q[`PTPI_CFG_INV_DIR];

   always_comb begin
      case (mode_q[`PTPI_MODE_CTRL])
         `PTPI_CTRL_POS: ctrl = PTPI_POSITION;
         `PTPI_CTRL_TRQ: ctrl = PTPI_TORQUE;
         default:        ctrl = PTPI_SPEED;
      endcase
   end

   assign pos_mode = (ctrl == PTPI_POSITION);

   ptpi_decode u_decode (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .en        (pos_mode),
      .fmt       (cfg_q[`PTPI_CFG_FMT]),
      .mult      (cfg_q[`PTPI_CFG_MULT]),
      .step      (step_e),
      .dir       (dir_e),
      .cmd_valid (cmd_valid),
      .cmd_rev   (cmd_rev)
   );

   always_comb begin
      case (cfg_q[`PTPI_CFG_CLRPOL])
         `PTPI_CLR_SVOFF: clear_act = clr_pin_act | servo_off;
         `PTPI_CLR_NEVER: clear_act = clr_pin_act;
         `PTPI_CLR_BOTH:  clear_act = clr_pin_act | servo_off | overtravel;
         default:         clear_act = clr_pin_act;
      endcase
   end

   always_comb begin
      cmd_term = '0;
      fb_term  = '0;
      if (cmd_valid) begin
         cmd_term = cmd_rev ? -$signed({2'b00, gear_q}) : $signed({2'b00, gear_q});
      end
      if (fb_count_valid) begin
         fb_term = fb_count_rev ? -34'sd1 : 34'sd1;
      end
      sum = 34'(dev_q) + cmd_term - fb_term;
      if (sum > 34'sh0_7FFF_FFFF) begin
         dev_d = 32'sh7FFF_FFFF;
      end else if (sum < -34'sh0_8000_0000) begin
         dev_d = 32'sh8000_0000;
      end else begin
         dev_d = 32'(sum);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dev_q <= '0;
      end else if (clear_act) begin
         dev_q <= '0;
      end else begin
         dev_q <= dev_d;
      end
   end

   assign dev_mag = dev_q[31] ? 32'(-dev_q) : dev_q;
   assign in_pos  = dev_mag <= position_done_out_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         speed_agree_out   <= 1'b1;
         position_done_out <= 1'b1;
      end else begin
         position_done_out <= ~(pos_mode & in_pos);
         case (ctrl)
            PTPI_POSITION: speed_agree_out <= ~in_pos;
            PTPI_TORQUE:   speed_agree_out <= 1'b1;
            default:       speed_agree_out <= ~speed_match_in;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         position_loop_en <= 1'b0;
      end else begin
         position_loop_en <= pos_mode & ~clear_act;
      end
   end

   a_pos_done_shown: assert property (@(posedge aclk) disable iff (!aresetn)
      pos_mode && in_pos |=> !speed_agree_out && !position_done_out)
      else $error("positioning done not shown on speed agree");

   a_torque_forced_high: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl == PTPI_TORQUE |=> speed_agree_out)
      else $error("speed agree not high in torque mode");

   a_idle_no_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
      !pos_mode ##1 !pos_mode && !clear_act && !fb_count_valid |=> $stable(dev_q))
      else $error("deviation moved outside position mode");

   a_invert_map: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_q[`PTPI_CFG_INV_STEP] |-> step_e != pin_s[0])
      else $error("step inversion not applied");

   a_clear_zeroes: assert property (@(posedge aclk) disable iff (!aresetn)
      clear_act |=> dev_q == 0)
      else $error("deviation not zero after clear");

   a_loop_held_off: assert property (@(posedge aclk) disable iff (!aresetn)
      clear_act [*2] |-> !position_loop_en)
      else $error("position loop enabled while clear held");

   a_policy0_ot: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_q[`PTPI_CFG_CLRPOL] == `PTPI_CLR_SVOFF && !clr_pin_act && !servo_off
      |-> !clear_act)
      else $error("overtravel cleared under policy 0");

   a_policy1_never: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_q[`PTPI_CFG_CLRPOL] == `PTPI_CLR_NEVER && !clr_pin_act |-> !clear_act)
      else $error("automatic clear under policy 1");

   a_policy2_both: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_q[`PTPI_CFG_CLRPOL] == `PTPI_CLR_BOTH && (servo_off || overtravel)
      |-> clear_act)
      else $error("policy 2 did not clear");

   a_gear_step_add: assert property (@(posedge aclk) disable iff (!aresetn)
      cmd_valid && !cmd_rev && !fb_count_valid && !clear_act
      && dev_q < 32'sh4000_0000 && dev_q >= 0
      |=> dev_q == $past(dev_q) + $signed(gear_q))
      else $error("command pulse not scaled by gear");

   a_fb_subtract: assert property (@(posedge aclk) disable iff (!aresetn)
      fb_count_valid && !fb_count_rev && !cmd_valid && !clear_act
      && dev_q != 32'sh8000_0000
      |=> dev_q == $past(dev_q) - 1)
      else $error("feedback count not subtracted");

endmodule

/* tb/ptpi_host.sv */
`timescale 1ns/100ps
`include "ptpi_regs.svh"
// Host controller: holds every level 3 cycles, above the 2-cycle minimum
module ptpi_host (
   input  wire logic aclk,
   output logic      step,
   output logic      dir
);
   logic [1:0] inv_q;
   initial begin
      inv_q = 2'h0;
      step = 1'b0;
      dir = 1'b0;
   end
   task automatic hold(input logic s, input logic d);
      step <= s ^ inv_q[1];
      dir <= d ^ inv_q[0];
      repeat (3) @(posedge aclk);
   endtask
   // Idle lines follow the polarity the drive is set to
   task automatic set_inv(input logic [1:0] c);
      inv_q = c;
      hold(1'b0, 1'b0);
   endtask
   task automatic train(input logic [1:0] fmt, input int n, input logic rev);
      repeat (n) begin
         case (fmt)
            `PTPI_FMT_STEP_DIR: begin
               hold(1'b0, !rev);
               hold(1'b1, !rev);
            end
            `PTPI_FMT_CW_CCW: begin
               hold(!rev, rev);
               hold(1'b0, 1'b0);
            end
            // Forward: phase A leads phase B
            default: begin
               hold(!rev, rev);
               hold(1'b1, 1'b1);
               hold(rev, !rev);
               hold(1'b0, 1'b0);
            end
         endcase
      end
      hold(1'b0, 1'b0);
   endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps
`include "ptpi_regs.svh"
module testbench
   import ptpi_pkg::*;
;
   logic       aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
   logic       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic       s_axi_bready, s_axi_rready, command_step_in, command_dir_in;
   logic       deviation_clear_in, servo_on_in, overtravel_in, fb_count_valid;
   logic       fb_count_rev, speed_match_in, speed_agree_out, position_done_out;
   logic       position_loop_en;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   ptpi_word_t s_axi_wdata, s_axi_rdata;
   int         n_errors, samples_checked, i;
   logic [15:0] cfg_v [12] = '{16'h0020, 16'h0000, 16'h0000, 16'h0100, 16'h0200, 16'h0300,
      16'h0010, 16'h0010, 16'h0030, 16'h1030, 16'h2030, 16'h3030};
   int          n_v [12] = '{2, 5, 3, 4, 2, 2, 3, 2, 2, 2, 2, 1};
   // Expected deviation with a gear of 3; format 2 decodes nothing
   int          cnt_v [12] = '{0, 15, -9, 12, 6, -6, 9, -6, 6, -12, 24, -12};
   int          off_v [3] = '{0, 6, 0};
   int          ot_v [3] = '{3, 9, 0};

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   ptpi_top ptpi_top_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .command_step_in, .command_dir_in,
      .deviation_clear_in, .servo_on_in, .overtravel_in, .fb_count_valid, .fb_count_rev,
      .speed_match_in, .speed_agree_out, .position_done_out, .position_loop_en);
   ptpi_host ptpi_host_i (.aclk(aclk), .step(command_step_in), .dir(command_dir_in));

   task automatic chk(input ptpi_word_t got, input ptpi_word_t exp);
      samples_checked++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         n_errors++;
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic give_up();
      n_errors++;
      close_out();
   endtask
   // Response waits: valid flags are registered, and are sampled mid-cycle like the combinational ready flags
   task automatic wait_resp(input logic rd_q, input ptpi_word_t exp, input logic [1:0] er);
      int   t;
      logic ok;
      ok = 1'b0;
      for (t = 0; t < 100 && !ok; t++) begin
         @(negedge aclk);
         ok = rd_q ? s_axi_rvalid : s_axi_bvalid;
         if (ok && rd_q) chk(s_axi_rdata, exp);
         if (ok) chk(ptpi_word_t'(rd_q ? s_axi_rresp : s_axi_bresp), ptpi_word_t'(er));
         @(posedge aclk);
      end
      if (!ok) give_up();
   endtask
   task automatic wr(input logic [7:0] a, input ptpi_word_t d, input logic [1:0] er);
      int   t;
      logic pa, pw, ta, tw;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      for (t = 0; t < 100 && (pa || pw); t++) begin
         @(negedge aclk);
         ta = pa && s_axi_awready;
         tw = pw && s_axi_wready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
      end
      if (pa || pw) give_up();
      wait_resp(1'b0, 32'h0000_0000, er);
   endtask
   task automatic rd(input logic [7:0] a, input ptpi_word_t exp, input logic [1:0] er);
      int   t;
      logic ta;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      ta = 1'b0;
      for (t = 0; t < 100 && !ta; t++) begin
         @(negedge aclk);
         ta = s_axi_arready;
         @(posedge aclk);
      end
      s_axi_arvalid <= 1'b0;
      if (!ta) give_up();
      wait_resp(1'b1, exp, er);
   endtask
   task automatic fb(input logic r, input int k);
      repeat (k) begin
         fb_count_rev <= r;
         fb_count_valid <= 1'b1;
         @(posedge aclk);
         fb_count_valid <= 1'b0;
         @(posedge aclk);
      end
   endtask
   task automatic clear_pulse();
      deviation_clear_in <= 1'b0;
      repeat (6) @(posedge aclk);
      chk(ptpi_word_t'(position_loop_en), 32'h0000_0000);
      rd(`PTPI_ADDR_DEV, 32'h0000_0000, `PTPI_RESP_OKAY);
      deviation_clear_in <= 1'b1;
      repeat (4) @(posedge aclk);
      chk(ptpi_word_t'(position_loop_en), 32'h0000_0001);
   endtask

   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, fb_count_valid, fb_count_rev} = 5'h00;
      {aresetn, overtravel_in, speed_match_in, s_axi_awaddr, s_axi_araddr} = 19'h0_0000;
      {s_axi_bready, s_axi_rready, deviation_clear_in, servo_on_in} = 4'hF;
      s_axi_wstrb = 4'hF;
      s_axi_wdata = 32'h0000_0000;
      n_errors = 0;
      samples_checked = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`PTPI_ADDR_CFG, 32'h0000_0000, `PTPI_RESP_OKAY);
      rd(`PTPI_ADDR_MODE, 32'h0000_0000, `PTPI_RESP_OKAY);
      rd(`PTPI_ADDR_GEAR, `PTPI_GEAR_RST, `PTPI_RESP_OKAY);
      rd(`PTPI_ADDR_POSITION_DONE_OUT, `PTPI_POSITION_DONE_OUT_RST, `PTPI_RESP_OKAY);
      rd(`PTPI_ADDR_RES, `PTPI_INC_LINES * `PTPI_QUAD_FACTOR, `PTPI_RESP_OKAY);
      rd(8'h1C, 32'h0000_0000, `PTPI_RESP_SLVERR);
      wr(8'h1C, 32'h0000_0005, `PTPI_RESP_SLVERR);
      chk(ptpi_word_t'(speed_agree_out), 32'h0000_0001);
      speed_match_in <= 1'b1;
      repeat (4) @(posedge aclk);
      chk(ptpi_word_t'(speed_agree_out), 32'h0000_0000);
      ptpi_host_i.train(`PTPI_FMT_STEP_DIR, 4, 1'b0);
      repeat (8) @(posedge aclk);
      rd(`PTPI_ADDR_DEV, 32'h0000_0000, `PTPI_RESP_OKAY);
      wr(`PTPI_ADDR_MODE, 32'h0000_0100, `PTPI_RESP_OKAY);
      rd(`PTPI_ADDR_RES, `PTPI_BUS_ENC_RES, `PTPI_RESP_OKAY);
      wr(`PTPI_ADDR_MODE, 32'h0000_0010, `PTPI_RESP_OKAY);
      wr(`PTPI_ADDR_GEAR, 32'h0000_0003, `PTPI_RESP_OKAY);
      wr(`PTPI_ADDR_POSITION_DONE_OUT, 32'h0000_0002, `PTPI_RESP_OKAY);
      for (i = 0; i < 12; i++) begin
         wr(`PTPI_ADDR_CFG, {16'h0000, cfg_v[i]}, `PTPI_RESP_OKAY);
         ptpi_host_i.set_inv(cfg_v[i][9:8]);
         clear_pulse();
         ptpi_host_i.train(cfg_v[i][5:4], n_v[i], cnt_v[i] < 0);
         repeat (8) @(posedge aclk);
         rd(`PTPI_ADDR_DEV, ptpi_word_t'(cnt_v[i]), `PTPI_RESP_OKAY);
      end
      chk(ptpi_word_t'(position_done_out), 32'h0000_0001);
      fb(1'b1, 11);
      repeat (4) @(posedge aclk);
      rd(`PTPI_ADDR_DEV, 32'hFFFF_FFFF, `PTPI_RESP_OKAY);
      chk(ptpi_word_t'(position_done_out), 32'h0000_0000);
      chk(ptpi_word_t'(speed_agree_out), 32'h0000_0000);
      rd(`PTPI_ADDR_STAT, 32'h0000_0003, `PTPI_RESP_OKAY);
      speed_match_in <= 1'b0;
      wr(`PTPI_ADDR_MODE, 32'h0000_0020, `PTPI_RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk(ptpi_word_t'(speed_agree_out), 32'h0000_0001);
      wr(`PTPI_ADDR_MODE, 32'h0000_0010, `PTPI_RESP_OKAY);
      fb(1'b0, 3);
      repeat (4) @(posedge aclk);
      rd(`PTPI_ADDR_DEV, 32'hFFFF_FFFC, `PTPI_RESP_OKAY);
      chk(ptpi_word_t'(speed_agree_out), 32'h0000_0001);
      for (i = 0; i < 3; i++) begin
         wr(`PTPI_ADDR_CFG, ptpi_word_t'(i), `PTPI_RESP_OKAY);
         ptpi_host_i.set_inv(2'h0);
         clear_pulse();
         ptpi_host_i.train(`PTPI_FMT_STEP_DIR, 2, 1'b0);
         servo_on_in <= 1'b0;
         repeat (6) @(posedge aclk);
         rd(`PTPI_ADDR_DEV, ptpi_word_t'(off_v[i]), `PTPI_RESP_OKAY);
         servo_on_in <= 1'b1;
         repeat (6) @(posedge aclk);
         ptpi_host_i.train(`PTPI_FMT_STEP_DIR, 1, 1'b0);
         overtravel_in <= 1'b1;
         repeat (6) @(posedge aclk);
         rd(`PTPI_ADDR_DEV, ptpi_word_t'(ot_v[i]), `PTPI_RESP_OKAY);
         overtravel_in <= 1'b0;
      end
      close_out();
   end
endmodule
